// [rtl/t16c_pkg.sv]
// shared constants, mode codes and state layout of the 16-bit timer counter and capture block
package t16c_pkg;

  // ------------------------------------------------------------------
  // register byte offsets on the wishbone bus (one 32-bit word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO   = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h0C;
  localparam logic [7:0] ADDR_CAP_LO   = 8'h10;
  localparam logic [7:0] ADDR_CAP_HI   = 8'h14;
  localparam logic [7:0] ADDR_CMPA_LO  = 8'h18;
  localparam logic [7:0] ADDR_CMPA_HI  = 8'h1C;
  localparam logic [7:0] ADDR_FLAGS    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h24;
  localparam logic [7:0] ADDR_CMP_CS   = 8'h28;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTRLB_FILTER_BIT = 7;
  localparam int unsigned CTRLB_EDGE_BIT   = 6;
  localparam int unsigned CTRLB_WGM_HI_LSB = 3;
  localparam int unsigned CTRLB_CS_LSB     = 0;
  localparam int unsigned FLAG_OVF_BIT     = 0;
  localparam int unsigned FLAG_CAP_BIT     = 5;
  localparam int unsigned CMPCS_SEL_BIT    = 2;

  // ------------------------------------------------------------------
  // clock source codes and count limits
  // ------------------------------------------------------------------
  localparam logic [2:0]  CS_STOP       = 3'h0;
  localparam logic [2:0]  CS_DIRECT     = 3'h1;
  localparam logic [2:0]  CS_PRESC_BASE = 3'h2;
  localparam logic [2:0]  CS_EXT_FALL   = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE   = 3'h7;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [15:0] COUNT_BOTTOM  = 16'h0000;
  localparam int unsigned FILTER_SAMPLES = 4;

  // ------------------------------------------------------------------
  // waveform generation modes
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_NORMAL    = 4'b0000, MODE_PC_8     = 4'b0001,
    MODE_PC_9      = 4'b0010, MODE_PC_10    = 4'b0011,
    MODE_CTC_CMP   = 4'b0100, MODE_FAST_8   = 4'b0101,
    MODE_FAST_9    = 4'b0110, MODE_FAST_10  = 4'b0111,
    MODE_PFC_CAP   = 4'b1000, MODE_PFC_CMP  = 4'b1001,
    MODE_PC_CAP    = 4'b1010, MODE_PC_CMP   = 4'b1011,
    MODE_CTC_CAP   = 4'b1100, MODE_RESERVED = 4'b1101,
    MODE_FAST_CAP  = 4'b1110, MODE_FAST_CMP = 4'b1111
  } t16c_mode_e;

  // ------------------------------------------------------------------
  // complete state of the block
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                wgm_lo;
    logic [7:0]                ctrl_b;
    logic                      cmp_sel;
    logic [15:0]               count;
    logic                      dir_down;
    logic [15:0]               capture;
    logic [15:0]               cmp_a;
    logic [7:0]                temp;
    logic                      ovf_flag;
    logic                      cap_flag;
    logic                      ovf_ie;
    logic                      cap_ie;
    logic                      src_meta;
    logic                      src_sync;
    logic [FILTER_SAMPLES-1:0] filt_sh;
    logic                      filt_out;
    logic                      edge_prev;
    logic                      tpin_meta;
    logic                      tpin_sync;
    logic                      tpin_prev;
    logic                      ack;
    logic [7:0]                rdata;
  } t16c_state_s;

  localparam t16c_state_s STATE_RESET = '0;

endpackage

// [rtl/t16c_timer.sv]
// 16-bit timer counter unit with input capture, wishbone register slave
// Operation
// - holding register keeps value between accesses
// - clock select zero stops the counter
// - each tick clears, increments or decrements
// - upper location uses holding; lower read loads it
// - cpu counter write beats count or clear
// - counter accessible whether or not ticking
// - provide count, direction, top, bottom
// - overflow flag set per mode, interrupt source
// - matching edge copies counter into capture
// - capture flag sets with the copy
// - enabled flag interrupts; service or write-one clears
// - capture lower read first loads holding register
// - capture writable only in capture-top modes
// - comparator select switches source; clear flag after
// - both inputs synchronised; filter adds four cycles
// - capture input dead in capture-top modes
// - port-driven pin changes also trigger capture
// - filter output moves when four samples agree
// - filter enable bit, runs on system clock
// - new capture always overwrites old value
// - lower write loads holding plus byte together
// - top is fixed value, capture or compare
`timescale 1ns/1ps
`default_nettype none

module t16c_timer (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  prescale_tick_i,
  input  wire logic        external_tick_pin_i,
  input  wire logic        capture_pin_i,
  input  wire logic        comparator_output_i,
  input  wire logic        overflow_irq_ack_i,
  input  wire logic        capture_irq_ack_i,
  output logic             overflow_irq_o,
  output logic             capture_irq_o,
  output logic      [15:0] count_value_o,
  output logic             count_down_o,
  output logic             top_o,
  output logic             bottom_o
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  // async assert, two-stage release so no flop sees a partial edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  t16c_pkg::t16c_state_s s;
  t16c_pkg::t16c_state_s next_s;
  t16c_pkg::t16c_mode_e  mode;
  logic [2:0]  cs;
  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;
  logic [15:0] wr_word;
  logic        wr_cnt_lo;
  logic        rd_cnt_lo;
  logic        rd_cap_lo;
  logic        wr_any_hi;
  logic        cap_top_mode;
  logic        dual_slope;
  logic        fast_mode;
  logic [15:0] top_val;
  logic        tick;
  logic        det_in;
  logic        cap_event;
  logic        flag_wr;

  assign mode = t16c_pkg::t16c_mode_e'({s.ctrl_b[t16c_pkg::CTRLB_WGM_HI_LSB +: 2], s.wgm_lo});
  assign cs   = s.ctrl_b[t16c_pkg::CTRLB_CS_LSB +: 3];

  // one access per bus cycle: the ack gate stops side effects repeating
  assign req       = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr        = req & wb_we_i & wb_sel_i[0];
  assign rd        = req & ~wb_we_i;
  assign wbyte     = wb_dat_i[7:0];
  assign wr_word   = {s.temp, wbyte};
  assign wr_cnt_lo = wr & (wb_adr_i == t16c_pkg::ADDR_CNT_LO);
  assign rd_cnt_lo = rd & (wb_adr_i == t16c_pkg::ADDR_CNT_LO);
  assign rd_cap_lo = rd & (wb_adr_i == t16c_pkg::ADDR_CAP_LO);
  assign flag_wr   = wr & (wb_adr_i == t16c_pkg::ADDR_FLAGS);
  assign wr_any_hi = wr & ((wb_adr_i == t16c_pkg::ADDR_CNT_HI) |
                           (wb_adr_i == t16c_pkg::ADDR_CAP_HI) |
                           (wb_adr_i == t16c_pkg::ADDR_CMPA_HI));

  // top value and slope class per mode
  always_comb begin
    cap_top_mode = 1'b0;
    dual_slope   = 1'b0;
    fast_mode    = 1'b0;
    top_val      = t16c_pkg::COUNT_MAX;
    case (mode)
      t16c_pkg::MODE_NORMAL:   top_val = t16c_pkg::COUNT_MAX;
      t16c_pkg::MODE_PC_8:     begin top_val = t16c_pkg::TOP_8BIT;  dual_slope = 1'b1; end
      t16c_pkg::MODE_PC_9:     begin top_val = t16c_pkg::TOP_9BIT;  dual_slope = 1'b1; end
      t16c_pkg::MODE_PC_10:    begin top_val = t16c_pkg::TOP_10BIT; dual_slope = 1'b1; end
      t16c_pkg::MODE_CTC_CMP:  top_val = s.cmp_a;
      t16c_pkg::MODE_FAST_8:   begin top_val = t16c_pkg::TOP_8BIT;  fast_mode = 1'b1; end
      t16c_pkg::MODE_FAST_9:   begin top_val = t16c_pkg::TOP_9BIT;  fast_mode = 1'b1; end
      t16c_pkg::MODE_FAST_10:  begin top_val = t16c_pkg::TOP_10BIT; fast_mode = 1'b1; end
      t16c_pkg::MODE_PFC_CAP,
      t16c_pkg::MODE_PC_CAP:   begin
        top_val      = s.capture;
        dual_slope   = 1'b1;
        cap_top_mode = 1'b1;
      end
      t16c_pkg::MODE_PFC_CMP,
      t16c_pkg::MODE_PC_CMP:   begin top_val = s.cmp_a; dual_slope = 1'b1; end
      t16c_pkg::MODE_CTC_CAP:  begin top_val = s.capture; cap_top_mode = 1'b1; end
      t16c_pkg::MODE_FAST_CAP: begin
        top_val      = s.capture;
        fast_mode    = 1'b1;
        cap_top_mode = 1'b1;
      end
      t16c_pkg::MODE_FAST_CMP: begin top_val = s.cmp_a; fast_mode = 1'b1; end
      default:                 top_val = t16c_pkg::COUNT_MAX; // reserved runs as normal
    endcase
  end

  // timer clock select; prescaler itself lives outside this block
  always_comb begin
    case (cs)
      t16c_pkg::CS_STOP:     tick = 1'b0;
      t16c_pkg::CS_DIRECT:   tick = 1'b1;
      t16c_pkg::CS_EXT_FALL: tick = s.tpin_prev & ~s.tpin_sync;
      t16c_pkg::CS_EXT_RISE: tick = ~s.tpin_prev & s.tpin_sync;
      default:               tick = prescale_tick_i[2'(cs - t16c_pkg::CS_PRESC_BASE)];
    endcase
  end

  // edge detector input: filtered or plain synchronised source
  assign det_in    = s.ctrl_b[t16c_pkg::CTRLB_FILTER_BIT] ? s.filt_out : s.src_sync;
  assign cap_event = (det_in != s.edge_prev) &
                     (det_in == s.ctrl_b[t16c_pkg::CTRLB_EDGE_BIT]) &
                     ~cap_top_mode;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // synchronisers; the meta stage feeds only the sync stage
    next_s.src_meta  = s.cmp_sel ? comparator_output_i : capture_pin_i;
    next_s.src_sync  = s.src_meta;
    next_s.tpin_meta = external_tick_pin_i;
    next_s.tpin_sync = s.tpin_meta;
    next_s.tpin_prev = s.tpin_sync;

    // noise filter: judged on the window with this sample in it, so it costs exactly four edges
    next_s.filt_sh = {s.filt_sh[t16c_pkg::FILTER_SAMPLES-2:0], s.src_sync};
    if (next_s.filt_sh == '1) begin
      next_s.filt_out = 1'b1;
    end else if (next_s.filt_sh == '0) begin
      next_s.filt_out = 1'b0;
    end
    next_s.edge_prev = det_in;

    // overflow clear goes before the count, so a set in the same cycle wins
    if ((flag_wr && wbyte[t16c_pkg::FLAG_OVF_BIT]) || overflow_irq_ack_i) begin
      next_s.ovf_flag = 1'b0;
    end

    // counter sequence
    if (tick) begin
      if (dual_slope) begin
        if (!s.dir_down) begin
          if (s.count >= top_val) begin
            next_s.dir_down = 1'b1;
            next_s.count    = s.count - 16'h0001;
          end else begin
            next_s.count = s.count + 16'h0001;
          end
        end else if (s.count == t16c_pkg::COUNT_BOTTOM) begin
          next_s.dir_down = 1'b0;
          next_s.count    = s.count + 16'h0001;
          next_s.ovf_flag = 1'b1;
        end else begin
          next_s.count = s.count - 16'h0001;
        end
      end else begin
        next_s.dir_down = 1'b0;
        if (s.count == top_val) begin
          next_s.count = t16c_pkg::COUNT_BOTTOM; // clear at top
        end else begin
          next_s.count = s.count + 16'h0001;
        end
        if ((fast_mode && s.count == top_val) || s.count == t16c_pkg::COUNT_MAX) begin
          next_s.ovf_flag = 1'b1;
        end
      end
    end

    // capture: always overwrites, flag in the same cycle
    if (cap_event) begin
      next_s.capture  = s.count;
      next_s.cap_flag = 1'b1;
    end

    // capture flag clear: service ack or write one; a coincident set wins
    if ((flag_wr && wbyte[t16c_pkg::FLAG_CAP_BIT]) || capture_irq_ack_i) begin
      next_s.cap_flag = cap_event;
    end

    // register writes; a counter write overrides any tick
    if (wr) begin
      case (wb_adr_i)
        t16c_pkg::ADDR_CTRL_A:  next_s.wgm_lo = wbyte[1:0];
        t16c_pkg::ADDR_CTRL_B:  next_s.ctrl_b = {wbyte[7:6], 1'b0, wbyte[4:0]};
        t16c_pkg::ADDR_CNT_HI,
        t16c_pkg::ADDR_CAP_HI,
        t16c_pkg::ADDR_CMPA_HI: next_s.temp = wbyte;
        t16c_pkg::ADDR_CNT_LO:  next_s.count = wr_word;
        t16c_pkg::ADDR_CAP_LO:  begin
          if (cap_top_mode) begin
            next_s.capture = wr_word;
          end
        end
        t16c_pkg::ADDR_CMPA_LO: next_s.cmp_a = wr_word;
        t16c_pkg::ADDR_IRQ_EN:  begin
          next_s.ovf_ie = wbyte[t16c_pkg::FLAG_OVF_BIT];
          next_s.cap_ie = wbyte[t16c_pkg::FLAG_CAP_BIT];
        end
        t16c_pkg::ADDR_CMP_CS:  next_s.cmp_sel = wbyte[t16c_pkg::CMPCS_SEL_BIT];
        default:                next_s.temp = s.temp; // unmapped writes vanish
      endcase
    end

    // register reads; counter and capture lower-byte reads latch the upper byte
    if (rd) begin
      case (wb_adr_i)
        t16c_pkg::ADDR_CTRL_A:  next_s.rdata = {6'h00, s.wgm_lo};
        t16c_pkg::ADDR_CTRL_B:  next_s.rdata = s.ctrl_b;
        t16c_pkg::ADDR_CNT_LO:  begin
          next_s.rdata = s.count[7:0];
          next_s.temp  = s.count[15:8];
        end
        t16c_pkg::ADDR_CAP_LO:  begin
          next_s.rdata = s.capture[7:0];
          next_s.temp  = s.capture[15:8];
        end
        t16c_pkg::ADDR_CNT_HI,
        t16c_pkg::ADDR_CAP_HI:  next_s.rdata = s.temp;
        t16c_pkg::ADDR_CMPA_LO: next_s.rdata = s.cmp_a[7:0];
        t16c_pkg::ADDR_CMPA_HI: next_s.rdata = s.cmp_a[15:8];
        t16c_pkg::ADDR_FLAGS:   begin
          next_s.rdata = 8'h00;
          next_s.rdata[t16c_pkg::FLAG_OVF_BIT] = s.ovf_flag;
          next_s.rdata[t16c_pkg::FLAG_CAP_BIT] = s.cap_flag;
        end
        t16c_pkg::ADDR_IRQ_EN:  begin
          next_s.rdata = 8'h00;
          next_s.rdata[t16c_pkg::FLAG_OVF_BIT] = s.ovf_ie;
          next_s.rdata[t16c_pkg::FLAG_CAP_BIT] = s.cap_ie;
        end
        t16c_pkg::ADDR_CMP_CS:  begin
          next_s.rdata = 8'h00;
          next_s.rdata[t16c_pkg::CMPCS_SEL_BIT] = s.cmp_sel;
        end
        default:                next_s.rdata = 8'h00;
      endcase
    end

    // single-cycle ack, dropped the cycle after
    next_s.ack = req;
  end

  // the one state register
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= t16c_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign wb_dat_o       = {24'h00_0000, s.rdata};
  assign wb_ack_o       = s.ack;
  assign overflow_irq_o = s.ovf_flag & s.ovf_ie;
  assign capture_irq_o  = s.cap_flag & s.cap_ie;
  assign count_value_o  = s.count;
  assign count_down_o   = s.dir_down;
  assign top_o          = (s.count == top_val);
  assign bottom_o       = (s.count == t16c_pkg::COUNT_BOTTOM);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking chk_cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n);
  // checks follow the released copy of reset, as the state register does

  count_stop_a: assert property ((cs == t16c_pkg::CS_STOP) && !wr_cnt_lo |=> $stable(s.count))
    else $error("counter moved with no clock source");

  count_write_a: assert property (wr_cnt_lo |=> s.count == $past(wr_word))
    else $error("counter write lost or merged with count");

  temp_load_a: assert property (rd_cnt_lo |=> s.temp == $past(s.count[15:8]))
    else $error("holding register not loaded on lower read");

  temp_hold_a: assert property (!wr_any_hi && !rd_cnt_lo && !rd_cap_lo |=> $stable(s.temp))
    else $error("holding register changed without access");

  capture_copy_a: assert property (cap_event |=> s.capture == $past(s.count) && s.cap_flag)
    else $error("capture copy or flag missing");

  flag_set_wins_a: assert property (cap_event && capture_irq_ack_i |=> s.cap_flag)
    else $error("capture flag lost to simultaneous clear");

  cap_mode_off_a: assert property (cap_top_mode &&
                                   !(wr && wb_adr_i == t16c_pkg::ADDR_CAP_LO) |=>
                                   $stable(s.capture))
    else $error("capture fired in capture-top mode");

  filter_agree_a: assert property (s.filt_out != $past(s.filt_out) |->
                                   s.filt_sh == {t16c_pkg::FILTER_SAMPLES{s.filt_out}})
    else $error("filter output changed without agreement");

  wrap_ovf_a: assert property (tick && mode == t16c_pkg::MODE_NORMAL && !wr_cnt_lo &&
                               s.count == t16c_pkg::COUNT_MAX |=> s.count == 16'h0000 ##0 s.ovf_flag)
    else $error("normal mode wrap without overflow");

  ack_pulse_a: assert property (req |=> s.ack ##1 !s.ack)
    else $error("ack not a single cycle");

  ovf_set_wins_a: assert property (tick && !dual_slope &&
                                   s.count == t16c_pkg::COUNT_MAX |=> s.ovf_flag)
    else $error("overflow set lost to a clear");

  dual_turn_a: assert property (tick && dual_slope && !s.dir_down &&
                                s.count >= top_val |=> s.dir_down)
    else $error("dual slope missed its turn at top");

  cap_refused_a: assert property (wr && !cap_top_mode && !cap_event &&
                                  wb_adr_i == t16c_pkg::ADDR_CAP_LO |=> $stable(s.capture))
    else $error("capture written outside capture-top mode");

  ack_only_req_a: assert property (!req |=> !s.ack)
    else $error("ack with no request");

endmodule

`default_nettype wire

// [testbench/t16c_far_end.sv]
// far-end model: port-driven capture pin, comparator level and prescaler ticks
`timescale 1ns/1ps
`default_nettype none

module t16c_far_end (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       port_level_i,
  input  wire logic       cmp_level_i,
  output logic      [3:0] prescale_tick_o,
  output logic            external_tick_pin_o,
  output logic            capture_pin_o,
  output logic            comparator_output_o
);
  logic [3:0] div;

  // free-running divider, each tick is a one-cycle pulse
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end
  assign prescale_tick_o = {div == 4'hF, div[2:0] == 3'h7, div[1:0] == 2'h3, div[0]};

  // pin follows the port bit, so software can trigger a capture
  assign capture_pin_o       = port_level_i;
  assign comparator_output_o = cmp_level_i;
  // no external count source fitted: the tick pin rests low
  assign external_tick_pin_o = 1'b0;
endmodule

`default_nettype wire

// [testbench/tb_t16c_timer.sv]
// self-checking bench for the 16-bit timer counter and capture block
`timescale 1ns/1ps
`default_nettype none

module tb_t16c_timer;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0000_0000;
  logic        cap_lvl = 1'b0;
  logic        cmp_lvl = 1'b0;
  logic        cap_ack = 1'b0;
  logic [31:0] rdat;
  logic        ack, ovf_irq, cap_irq, down, top, bottom, ext_pin, cap_pin, cmp_out;
  logic [15:0] cnt;
  logic [3:0]  ptick;
  logic [7:0]  q;
  logic [15:0] v;
  int          errors = 0;
  int          samples_checked = 0;

  always #4 clock_i = ~clock_i;

  t16c_far_end u_t16c_far_end (.clock_i(clock_i), .rst_n_i(rst_n_i), .port_level_i(cap_lvl),
    .cmp_level_i(cmp_lvl), .prescale_tick_o(ptick), .external_tick_pin_o(ext_pin),
    .capture_pin_o(cap_pin), .comparator_output_o(cmp_out));

  t16c_timer u_t16c_timer (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .prescale_tick_i(ptick), .external_tick_pin_i(ext_pin),
    .capture_pin_i(cap_pin), .comparator_output_i(cmp_out), .overflow_irq_ack_i(1'b0),
    .capture_irq_ack_i(cap_ack), .overflow_irq_o(ovf_irq), .capture_irq_o(cap_irq),
    .count_value_o(cnt), .count_down_o(down), .top_o(top), .bottom_o(bottom));

  // ------------------------------------------------------------------
  // verdict, comparison and bus access
  // ------------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ack and read data are taken at the rising edge, before that edge's updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      errors++;
      conclude();
    end
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask

  // rising edges from a pin change up to the one that sets the capture flag
  task automatic lat(input int exp);
    int n;
    n = 0;
    @(negedge clock_i);
    while (cap_irq !== 1'b1 && n < 12) begin
      @(negedge clock_i);
      n++;
    end
    chk("capture latency", 16'(exp), 16'(n));
    @(posedge clock_i);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_access();
    wr(t16c_pkg::ADDR_CNT_HI, 8'h12);
    wr(t16c_pkg::ADDR_CNT_LO, 8'h34);
    chk("count", 16'h1234, cnt);
    rd(t16c_pkg::ADDR_CNT_LO);
    chk("count lower", 16'h0034, {8'h00, q});
    rd(t16c_pkg::ADDR_CNT_HI);
    chk("count upper", 16'h0012, {8'h00, q});
    wr(t16c_pkg::ADDR_CMPA_LO, 8'h56);
    rd(t16c_pkg::ADDR_CMPA_HI);
    chk("reused upper", 16'h0012, {8'h00, q});
    rd(8'h3C);
    chk("unmapped", 16'h0000, {8'h00, q});
  endtask

  task automatic t_run();
    @(negedge clock_i);
    v = cnt;
    repeat (5) @(negedge clock_i);
    chk("stopped count", v, cnt);
    @(posedge clock_i);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h01);
    @(negedge clock_i);
    v = cnt;
    @(negedge clock_i);
    chk("increment", v + 16'h0001, cnt);
    @(posedge clock_i);
    wr(t16c_pkg::ADDR_CNT_HI, 8'h00);
    wr(t16c_pkg::ADDR_CNT_LO, 8'h10);
    @(negedge clock_i);
    chk("write beats count", 16'h0012, cnt);
    @(posedge clock_i);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h02);
    @(negedge clock_i);
    v = cnt;
    repeat (4) @(negedge clock_i);
    chk("prescaled count", v + 16'h0002, cnt);
    @(posedge clock_i);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h01);
  endtask

  // dual slope with a fixed top: turns down after reaching it
  task automatic t_dual();
    wr(t16c_pkg::ADDR_CTRL_A, 8'h01);
    wr(t16c_pkg::ADDR_CNT_HI, 8'h00);
    wr(t16c_pkg::ADDR_CNT_LO, 8'hFE);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h01);
    repeat (3) @(negedge clock_i);
    chk("down count", 16'h0001, {15'h0000, down});
    chk("turned at top", 16'h00FC, cnt);
    @(posedge clock_i);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
    wr(t16c_pkg::ADDR_CTRL_A, 8'h00);
  endtask

  task automatic t_overflow();
    int n;
    wr(t16c_pkg::ADDR_IRQ_EN, 8'h01);
    wr(t16c_pkg::ADDR_CNT_HI, 8'hFF);
    wr(t16c_pkg::ADDR_CNT_LO, 8'hF0);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (top !== 1'b1 && n < 40);
    chk("top value", 16'hFFFF, cnt);
    @(negedge clock_i);
    chk("bottom", 16'h0001, {15'h0000, bottom});
    chk("overflow irq", 16'h0001, {15'h0000, ovf_irq});
    @(posedge clock_i);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
    rd(t16c_pkg::ADDR_FLAGS);
    chk("flags", 16'h0001, {8'h00, q});
    wr(t16c_pkg::ADDR_FLAGS, 8'h01);
    chk("overflow cleared", 16'h0000, {15'h0000, ovf_irq});
  endtask

  task automatic t_capture();
    wr(t16c_pkg::ADDR_CTRL_B, 8'h40);
    wr(t16c_pkg::ADDR_IRQ_EN, 8'h20);
    wr(t16c_pkg::ADDR_CNT_HI, 8'h01);
    wr(t16c_pkg::ADDR_CNT_LO, 8'h23);
    cap_lvl <= 1'b1;
    lat(3);
    rd(t16c_pkg::ADDR_CAP_LO);
    chk("capture lower", 16'h0023, {8'h00, q});
    rd(t16c_pkg::ADDR_CAP_HI);
    chk("capture upper", 16'h0001, {8'h00, q});
    wr(t16c_pkg::ADDR_CNT_HI, 8'h04);
    wr(t16c_pkg::ADDR_CNT_LO, 8'h56);
    cap_lvl <= 1'b0;
    repeat (8) @(posedge clock_i);
    rd(t16c_pkg::ADDR_CAP_LO);
    chk("falling ignored", 16'h0023, {8'h00, q});
    cap_lvl <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(t16c_pkg::ADDR_CAP_LO);
    chk("overwrite lower", 16'h0056, {8'h00, q});
    rd(t16c_pkg::ADDR_CAP_HI);
    chk("overwrite upper", 16'h0004, {8'h00, q});
    cap_ack <= 1'b1;
    @(posedge clock_i);
    cap_ack <= 1'b0;
    @(negedge clock_i);
    chk("serviced flag", 16'h0000, {15'h0000, cap_irq});
    @(posedge clock_i);
  endtask

  task automatic t_filter();
    wr(t16c_pkg::ADDR_CTRL_B, 8'hC0);
    cap_lvl <= 1'b0;
    repeat (10) @(posedge clock_i);
    wr(t16c_pkg::ADDR_FLAGS, 8'h20);
    cap_lvl <= 1'b1;
    repeat (2) @(posedge clock_i);
    cap_lvl <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk("glitch rejected", 16'h0000, {15'h0000, cap_irq});
    cap_lvl <= 1'b1;
    lat(7);
  endtask

  task automatic t_source();
    wr(t16c_pkg::ADDR_CTRL_B, 8'h40);
    wr(t16c_pkg::ADDR_CMP_CS, 8'h04);
    repeat (6) @(posedge clock_i);
    wr(t16c_pkg::ADDR_FLAGS, 8'h20);
    cmp_lvl <= 1'b1;
    lat(3);
    rd(t16c_pkg::ADDR_CAP_LO);
    wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
    wr(t16c_pkg::ADDR_FLAGS, 8'h20);
    cmp_lvl <= 1'b0;
    lat(3);
  endtask

  task automatic t_cap_top();
    wr(t16c_pkg::ADDR_CAP_HI, 8'hAA);
    wr(t16c_pkg::ADDR_CAP_LO, 8'hBB);
    rd(t16c_pkg::ADDR_CAP_LO);
    chk("capture write refused", 16'h0056, {8'h00, q});
    wr(t16c_pkg::ADDR_CTRL_B, 8'h58);
    wr(t16c_pkg::ADDR_FLAGS, 8'h20);
    wr(t16c_pkg::ADDR_CAP_HI, 8'h00);
    wr(t16c_pkg::ADDR_CAP_LO, 8'h30);
    rd(t16c_pkg::ADDR_CAP_LO);
    chk("capture write taken", 16'h0030, {8'h00, q});
    wr(t16c_pkg::ADDR_CNT_LO, 8'h30);
    chk("top from capture", 16'h0001, {15'h0000, top});
    cmp_lvl <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk("capture input idle", 16'h0000, {15'h0000, cap_irq});
  endtask

  // ------------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_access();
    t_run();
    t_overflow();
    t_dual();
    t_capture();
    t_filter();
    t_source();
    t_cap_top();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
